// >>> coad_pkg.sv
// Shared types and constants for the operand addressing decoder
package coad_pkg;

	localparam int ADDR_W = 16;
	localparam int REG_IDX_W = 3;
	localparam int INSN_TYPES = 57;
	localparam logic [7:0] TOP_PAGE = 8'hFF;
	localparam logic [7:0] ZERO_PAGE = 8'h00;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [2:0] SP_IDX = 3'h7;

	// Addressing modes of an operand
	typedef enum logic [3:0] {
		AM_REG = 4'h0,
		AM_REG_IND = 4'h1,
		AM_DISP16 = 4'h2,
		AM_POST_INC = 4'h3,
		AM_PRE_DEC = 4'h4,
		AM_ABS8 = 4'h5,
		AM_ABS16 = 4'h6,
		AM_IMM = 4'h7,
		AM_PC_REL = 4'h8,
		AM_MEM_IND = 4'h9
	} coad_mode_e;

	// Operation groups seen by the decoder
	typedef enum logic [3:0] {
		OP_MOV = 4'h0,
		OP_PUSH = 4'h1,
		OP_POP = 4'h2,
		OP_PERIPH_TO = 4'h3,
		OP_PERIPH_FROM = 4'h4,
		OP_ALU_IMM_OK = 4'h5,
		OP_ALU_REG_ONLY = 4'h6,
		OP_BIT_REGNUM_OK = 4'h7,
		OP_BIT_IMMNUM = 4'h8,
		OP_BCC = 4'h9,
		OP_JUMP = 4'hA,
		OP_BSR = 4'hB,
		OP_SYSTEM = 4'hC,
		OP_BLOCK_COPY = 4'hD
	} coad_op_e;

	// Instruction classes, total types per class
	typedef enum logic [2:0] {
		CL_TRANSFER = 3'h0,
		CL_ARITH = 3'h1,
		CL_LOGIC = 3'h2,
		CL_SHIFT = 3'h3,
		CL_BIT = 3'h4,
		CL_BRANCH = 3'h5,
		CL_SYSTEM = 3'h6,
		CL_BLOCK = 3'h7
	} coad_class_e;

	localparam logic [5:0] TYPES_TRANSFER = 6'h03;
	localparam logic [5:0] TYPES_ARITH = 6'h0E;
	localparam logic [5:0] TYPES_LOGIC = 6'h04;
	localparam logic [5:0] TYPES_SHIFT = 6'h08;
	localparam logic [5:0] TYPES_BIT = 6'h0E;
	localparam logic [5:0] TYPES_BRANCH = 6'h05;
	localparam logic [5:0] TYPES_SYSTEM = 6'h08;
	localparam logic [5:0] TYPES_BLOCK = 6'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INDIRECT = 2'b01,
		ST_DONE = 2'b11
	} coad_state_e;

	// Decoded request from the fetch stage
	typedef struct packed {
		coad_op_e op;
		coad_mode_e mode;
		logic word;
		logic store;
		logic [2:0] reg_n;
		logic [2:0] reg_m;
		logic [2:0] bit_imm;
		logic bit_from_reg;
		logic [3:0] cond;
		logic [15:0] ext;
		logic [15:0] pc;
	} coad_insn_s;

	// Result handed to the execute stage
	typedef struct packed {
		logic illegal;
		coad_class_e iclass;
		logic mem_access;
		logic mem_write;
		logic word;
		logic [15:0] ea;
		logic [15:0] imm;
		logic imm_valid;
		logic [2:0] bit_num;
		logic bit_num_reg;
		logic [2:0] bit_reg;
		logic [3:0] cond;
		logic [15:0] new_reg_val;
		logic reg_update;
		logic [2:0] reg_update_idx;
		logic [15:0] target;
		logic target_valid;
	} coad_result_s;

endpackage

// >>> coad_decode.sv
// Operand addressing and effective address decoder
// What this block does
// - Arithmetic, logic, shift take register operands only, except listed byte immediates.
// - Byte add, add_with_carry, subtract_with_borrow, compare, and, or, xor accept immediates.
// - Move rejects PC-relative and memory indirect modes.
// - Bit ops use register, register indirect or 8-bit absolute; bit by 3-bit immediate.
// - bit_set_op, bit_clear_op, bit_invert_op, bit_test_op may take bit number from register.
// - 8-bit absolute address gets upper byte forced to ones.
// - Immediate operand comes from instruction stream, one or two bytes, no memory access.
// - PC-relative target is PC plus sign-extended 8-bit displacement, with bit zero forced low.
// - Memory indirect reads a zero-page word and uses it, bit zero forced low, as branch target.
// - Word accesses force address bit zero low without error.
// - Fifty-seven instruction types grouped into eight classes.
// - Push equals word move of register with stack pointer pre-decrement.
// - Pop equals word move from stack pointer post-increment into register.
// - Conditional branch carries a condition code field.
// - Peripheral moves to and from are unsupported and rejected.
// - Move covers register-register, register-memory and immediate load, byte or word.
// - Listed modes serve byte or word moves; 8-bit absolute serves byte only.
module coad_decode #(
	parameter int ADDR_W = coad_pkg::ADDR_W
)(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire coad_pkg::coad_insn_s insn_i,
	input wire logic [ADDR_W-1:0] reg_n_val_i,
	input wire logic [ADDR_W-1:0] reg_m_val_i,
	output logic req_ready_o,
	output logic mem_rd_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	output logic res_valid_o,
	output coad_pkg::coad_result_s res_o
);

	coad_pkg::coad_state_e state;
	coad_pkg::coad_state_e next_state;
	coad_pkg::coad_result_s res;
	coad_pkg::coad_result_s next_res;
	logic [ADDR_W-1:0] ind_addr;

	// Word access ignores address bit zero
	function automatic logic [15:0] word_align(input logic [15:0] a, input logic w);
		word_align = w ? {a[15:1], 1'b0} : a;
	endfunction

	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		add16 = s[15:0];
	endfunction

	function automatic coad_pkg::coad_class_e class_of(input coad_pkg::coad_op_e op);
		case (op)
			coad_pkg::OP_MOV, coad_pkg::OP_PUSH, coad_pkg::OP_POP,
			coad_pkg::OP_PERIPH_TO, coad_pkg::OP_PERIPH_FROM: class_of = coad_pkg::CL_TRANSFER;
			coad_pkg::OP_ALU_IMM_OK, coad_pkg::OP_ALU_REG_ONLY: class_of = coad_pkg::CL_ARITH;
			coad_pkg::OP_BIT_REGNUM_OK, coad_pkg::OP_BIT_IMMNUM: class_of = coad_pkg::CL_BIT;
			coad_pkg::OP_BCC, coad_pkg::OP_JUMP, coad_pkg::OP_BSR: class_of = coad_pkg::CL_BRANCH;
			coad_pkg::OP_BLOCK_COPY: class_of = coad_pkg::CL_BLOCK;
			default: class_of = coad_pkg::CL_SYSTEM;
		endcase
	endfunction

	wire coad_pkg::coad_op_e op = insn_i.op;
	wire coad_pkg::coad_mode_e mode = insn_i.mode;
	wire is_push = (op == coad_pkg::OP_PUSH);
	wire is_pop = (op == coad_pkg::OP_POP);
	wire is_mov = (op == coad_pkg::OP_MOV);
	wire is_stack = is_push || is_pop;
	// Push and pop map onto word moves through the stack pointer
	wire coad_pkg::coad_mode_e eff_mode = is_push ? coad_pkg::AM_PRE_DEC :
		(is_pop ? coad_pkg::AM_POST_INC : mode);
	wire eff_word = is_stack ? 1'b1 : insn_i.word;
	wire eff_store = is_push ? 1'b1 : (is_pop ? 1'b0 : insn_i.store);

	wire mode_reg = (mode == coad_pkg::AM_REG);
	wire mode_imm = (mode == coad_pkg::AM_IMM);
	wire alu_imm_ok = mode_reg || (mode_imm && !insn_i.word);
	wire alu_reg_ok = mode_reg;
	wire bit_mode_ok = mode_reg || (mode == coad_pkg::AM_REG_IND) ||
		(mode == coad_pkg::AM_ABS8);
	wire mov_mode_ok = (mode != coad_pkg::AM_PC_REL) && (mode != coad_pkg::AM_MEM_IND) &&
		!(mode == coad_pkg::AM_ABS8 && insn_i.word) &&
		!(mode == coad_pkg::AM_IMM && insn_i.store);
	wire jump_mode_ok = (mode == coad_pkg::AM_REG_IND) || (mode == coad_pkg::AM_ABS16) ||
		(mode == coad_pkg::AM_MEM_IND);

	logic legal;
	always_comb
	begin
		case (op)
			coad_pkg::OP_MOV: legal = mov_mode_ok;
			coad_pkg::OP_PUSH, coad_pkg::OP_POP: legal = 1'b1;
			coad_pkg::OP_PERIPH_TO, coad_pkg::OP_PERIPH_FROM: legal = 1'b0;
			coad_pkg::OP_ALU_IMM_OK: legal = alu_imm_ok;
			coad_pkg::OP_ALU_REG_ONLY: legal = alu_reg_ok;
			coad_pkg::OP_BIT_REGNUM_OK: legal = bit_mode_ok;
			coad_pkg::OP_BIT_IMMNUM: legal = bit_mode_ok && !insn_i.bit_from_reg;
			coad_pkg::OP_BCC, coad_pkg::OP_BSR: legal = (mode == coad_pkg::AM_PC_REL);
			coad_pkg::OP_JUMP: legal = jump_mode_ok;
			coad_pkg::OP_SYSTEM, coad_pkg::OP_BLOCK_COPY: legal = 1'b1;
			default: legal = 1'b0;
		endcase
	end

	// Address base: always the pointer register value reg_m_val_i, stack ops included; only the update index is the stack pointer
	wire [15:0] base = reg_m_val_i;
	wire [15:0] step = eff_word ? coad_pkg::STEP_WORD : coad_pkg::STEP_BYTE;
	wire [15:0] pre_dec = add16(base, ~step + 16'h0001);
	wire [15:0] post_inc = add16(base, step);
	wire [15:0] disp_ea = add16(base, insn_i.ext);
	wire [15:0] abs8_ea = {coad_pkg::TOP_PAGE, insn_i.ext[7:0]};
	wire [15:0] rel_disp = {{8{insn_i.ext[7]}}, insn_i.ext[7:0]};
	wire [15:0] pc_rel = add16(insn_i.pc, rel_disp);
	wire [15:0] zp_addr = {coad_pkg::ZERO_PAGE, insn_i.ext[7:0]};
	wire [2:0] ptr_idx = is_stack ? coad_pkg::SP_IDX : insn_i.reg_m;

	logic [15:0] raw_ea;
	always_comb
	begin
		case (eff_mode)
			coad_pkg::AM_REG_IND, coad_pkg::AM_POST_INC: raw_ea = base;
			coad_pkg::AM_DISP16: raw_ea = disp_ea;
			coad_pkg::AM_PRE_DEC: raw_ea = pre_dec;
			coad_pkg::AM_ABS8: raw_ea = abs8_ea;
			coad_pkg::AM_ABS16: raw_ea = insn_i.ext;
			coad_pkg::AM_PC_REL: raw_ea = pc_rel;
			coad_pkg::AM_MEM_IND: raw_ea = zp_addr;
			default: raw_ea = 16'h0000;
		endcase
	end

	wire mem_mode = (eff_mode != coad_pkg::AM_REG) && (eff_mode != coad_pkg::AM_IMM) &&
		(eff_mode != coad_pkg::AM_PC_REL) && (eff_mode != coad_pkg::AM_MEM_IND);
	wire is_branch = (op == coad_pkg::OP_BCC) || (op == coad_pkg::OP_BSR) || (op == coad_pkg::OP_JUMP);
	wire take = req_valid_i && (state == coad_pkg::ST_IDLE);
	wire go_ind = take && legal && (eff_mode == coad_pkg::AM_MEM_IND);

	always_comb
	begin
		next_res = res;
		next_state = state;
		case (state)
			coad_pkg::ST_IDLE:
			begin
				if (req_valid_i)
				begin
					next_res = '0;
					next_res.illegal = !legal;
					next_res.iclass = class_of(op);
					next_res.word = eff_word;
					next_res.cond = (op == coad_pkg::OP_BCC) ? insn_i.cond : 4'h0;
					next_res.bit_num = insn_i.bit_imm;
					next_res.bit_num_reg = insn_i.bit_from_reg &&
						(op == coad_pkg::OP_BIT_REGNUM_OK);
					next_res.bit_reg = insn_i.reg_n;
					if (legal)
					begin
						next_res.ea = word_align(raw_ea, eff_word && !is_branch);
						next_res.mem_access = mem_mode && !is_branch && (op != coad_pkg::OP_SYSTEM);
						next_res.mem_write = mem_mode && eff_store && !is_branch && (op != coad_pkg::OP_SYSTEM);
						next_res.imm_valid = (eff_mode == coad_pkg::AM_IMM);
						next_res.imm = eff_word ? insn_i.ext : {8'h00, insn_i.ext[7:0]};
						next_res.reg_update = (is_mov || is_stack) &&
							((eff_mode == coad_pkg::AM_PRE_DEC) || (eff_mode == coad_pkg::AM_POST_INC));
						next_res.reg_update_idx = ptr_idx;
						next_res.new_reg_val = (eff_mode == coad_pkg::AM_PRE_DEC) ? pre_dec : post_inc;
						next_res.target = word_align(is_branch && eff_mode == coad_pkg::AM_REG_IND ?
							base : raw_ea, 1'b1);
						next_res.target_valid = is_branch && !(eff_mode == coad_pkg::AM_MEM_IND);
					end
					next_state = go_ind ? coad_pkg::ST_INDIRECT : coad_pkg::ST_DONE;
				end
			end
			coad_pkg::ST_INDIRECT:
			begin
				if (mem_ack_i)
				begin
					next_res.target = word_align(mem_rdata_i, 1'b1);
					next_res.target_valid = 1'b1;
					next_state = coad_pkg::ST_DONE;
				end
			end
			coad_pkg::ST_DONE: next_state = coad_pkg::ST_IDLE;
			default: next_state = coad_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			state <= coad_pkg::ST_IDLE;
			res <= '0;
			ind_addr <= '0;
		end
		else
		begin
			state <= next_state;
			res <= next_res;
			if (go_ind)
				ind_addr <= word_align(zp_addr, 1'b1);
		end
	end

	assign req_ready_o = (state == coad_pkg::ST_IDLE);
	assign mem_rd_o = (state == coad_pkg::ST_INDIRECT);
	assign mem_addr_o = ind_addr;
	assign res_valid_o = (state == coad_pkg::ST_DONE);
	assign res_o = res;

endmodule

// >>> coad_mem_model.sv
// Memory model answering indirect word fetches of the decoder
module coad_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] lat_i,
	output logic [15:0] rdata_o,
	output logic ack_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		cnt <= 4'h0;
		if (rst_i)
			rdata_o <= 16'h0000;
		else if (rd_i && !ack_o)
		begin
			cnt <= cnt + 4'h1;
			if (cnt == lat_i)
			begin
				// Pointer word is odd on purpose
				ack_o <= 1'b1;
				rdata_o <= {8'hC3, addr_i[7:0] | 8'h01};
			end
		end
	end
endmodule

// >>> coad_decode_chk.sv
// Assertion checker for the operand addressing decoder
module coad_decode_chk #(
	parameter int ADDR_W = 16
)(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire coad_pkg::coad_insn_s insn_i,
	input wire logic [ADDR_W-1:0] reg_m_val_i,
	input wire logic req_ready_o,
	input wire logic mem_rd_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic res_valid_o,
	input wire coad_pkg::coad_result_s res_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire take = req_valid_i && req_ready_o;
	wire mov = take && insn_i.op == coad_pkg::OP_MOV;
	ready_back_a: assert property (res_valid_o |=> req_ready_o && !res_valid_o)
		else $error("ready not back after result");
	abs8_page_a: assert property (mov && insn_i.mode == coad_pkg::AM_ABS8 && !insn_i.word
		|=> !res_o.illegal && res_o.ea == ($past(insn_i.ext) | 16'hFF00)) else $error("short address page wrong");
	mov_reject_a: assert property (mov && insn_i.mode inside {coad_pkg::AM_PC_REL, coad_pkg::AM_MEM_IND}
		|=> res_o.illegal && !res_o.target_valid) else $error("move mode not refused");
	periph_reject_a: assert property (take && insn_i.op inside {coad_pkg::OP_PERIPH_TO, coad_pkg::OP_PERIPH_FROM}
		|=> res_o.illegal && !res_o.mem_access) else $error("peripheral move not refused");
	ind_addr_a: assert property (mem_rd_o |-> mem_addr_o[15:8] == 8'h00 && !mem_addr_o[0])
		else $error("pointer fetch address wrong");
	ind_target_a: assert property (mem_rd_o && mem_ack_i |=> res_valid_o
		&& res_o.target == ($past(mem_rdata_i) & 16'hFFFE)) else $error("indirect target wrong");
	push_ea_a: assert property (take && insn_i.op == coad_pkg::OP_PUSH |=> res_o.mem_write && res_o.word
		&& res_o.ea == $past(reg_m_val_i) - 16'h0002) else $error("push address wrong");
	pop_ea_a: assert property (take && insn_i.op == coad_pkg::OP_POP |=> !res_o.mem_write
		&& res_o.new_reg_val == $past(reg_m_val_i) + 16'h0002) else $error("pop pointer wrong");
	cover property (take && insn_i.op == coad_pkg::OP_PUSH);
	cover property (mem_rd_o && mem_ack_i);
	cover property (mov && insn_i.mode == coad_pkg::AM_ABS8);
endmodule
bind coad_decode coad_decode_chk #(.ADDR_W(ADDR_W)) chk_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.req_valid_i(req_valid_i), .insn_i(insn_i), .reg_m_val_i(reg_m_val_i), .req_ready_o(req_ready_o),
	.mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
	.res_valid_o(res_valid_o), .res_o(res_o));

// >>> tb_coad_decode.sv
// Testbench for the operand addressing decoder
module tb_coad_decode;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 0, sys_rst_i = 1, req_valid_i = 0, bfr = 0;
	logic req_ready_o, mem_rd_o, mem_ack_i, res_valid_o;
	logic [15:0] reg_n_val_i = 16'h1234, reg_m_val_i = 16'h0000, mem_addr_o, mem_rdata_i;
	logic [3:0] lat = 4'h0;
	coad_pkg::coad_insn_s insn_i = '0;
	coad_pkg::coad_result_s res_o;
	int mismatches = 0, compares = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	coad_decode dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .insn_i(insn_i),
		.reg_n_val_i(reg_n_val_i), .reg_m_val_i(reg_m_val_i), .req_ready_o(req_ready_o), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .res_valid_o(res_valid_o),
		.res_o(res_o));
	coad_mem_model mem_u (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
		.lat_i(lat), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
	task automatic stop_test();
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(input coad_pkg::coad_op_e op, input coad_pkg::coad_mode_e md, input logic w, input logic st,
		input logic [15:0] x);
		int n;
		n = 0;
		insn_i = '{op: op, mode: md, word: w, store: st, reg_n: 3'h1, reg_m: 3'h7, bit_imm: 3'h5,
			bit_from_reg: bfr, cond: 4'hA, ext: x, pc: 16'h1000};
		req_valid_i = 1'b1;
		@(posedge sys_clk_i);
		#1 req_valid_i = 1'b0;
		while (res_valid_o !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk("res_valid", res_valid_o, 1'b1);
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic t_move();
		run(coad_pkg::OP_MOV, coad_pkg::AM_ABS8, 0, 0, 16'h0042);
		chk("abs8", res_o.ea, 16'hFF42);
		chk("class", res_o.iclass, coad_pkg::CL_TRANSFER);
		run(coad_pkg::OP_MOV, coad_pkg::AM_ABS8, 1, 0, 16'h0042);
		chk("abs8w", res_o.illegal, 1'b1);
		reg_m_val_i = 16'hFFF0;
		run(coad_pkg::OP_MOV, coad_pkg::AM_DISP16, 1, 1, 16'h0013);
		chk("disp", res_o.ea, 16'h0002);
		chk("wr", res_o.mem_write, 1'b1);
		run(coad_pkg::OP_MOV, coad_pkg::AM_IMM, 0, 0, 16'h12AB);
		chk("immb", res_o.imm, 16'h00AB);
		chk("immv", res_o.imm_valid, 1'b1);
		chk("immacc", res_o.mem_access, 1'b0);
		run(coad_pkg::OP_MOV, coad_pkg::AM_IMM, 1, 0, 16'h12AB);
		chk("immw", res_o.imm, 16'h12AB);
		run(coad_pkg::OP_MOV, coad_pkg::AM_REG, 1, 0, 16'h0000);
		chk("regmov", {res_o.illegal, res_o.mem_access}, 2'b00);
		run(coad_pkg::OP_MOV, coad_pkg::AM_PC_REL, 0, 0, 16'h0010);
		chk("movpc", res_o.illegal, 1'b1);
		run(coad_pkg::OP_MOV, coad_pkg::AM_MEM_IND, 1, 0, 16'h0010);
		chk("movind", res_o.illegal, 1'b1);
	endtask
	task automatic t_alu();
		run(coad_pkg::OP_ALU_IMM_OK, coad_pkg::AM_IMM, 0, 0, 16'h0055);
		chk("aluimm", res_o.illegal, 1'b0);
		run(coad_pkg::OP_ALU_IMM_OK, coad_pkg::AM_IMM, 1, 0, 16'h0055);
		chk("aluimmw", res_o.illegal, 1'b1);
		run(coad_pkg::OP_ALU_REG_ONLY, coad_pkg::AM_IMM, 0, 0, 16'h0055);
		chk("regonly", res_o.illegal, 1'b1);
		run(coad_pkg::OP_ALU_REG_ONLY, coad_pkg::AM_REG_IND, 0, 0, 16'h0000);
		chk("aluind", res_o.illegal, 1'b1);
		run(coad_pkg::OP_ALU_REG_ONLY, coad_pkg::AM_REG, 0, 0, 16'h0000);
		chk("alureg", res_o.illegal, 1'b0);
	endtask
	task automatic t_bit();
		run(coad_pkg::OP_BIT_IMMNUM, coad_pkg::AM_ABS8, 0, 0, 16'h0010);
		chk("bitea", res_o.ea, 16'hFF10);
		chk("bitnum", res_o.bit_num, 3'h5);
		run(coad_pkg::OP_BIT_IMMNUM, coad_pkg::AM_DISP16, 0, 0, 16'h0010);
		chk("bitdisp", res_o.illegal, 1'b1);
		bfr = 1'b1;
		run(coad_pkg::OP_BIT_REGNUM_OK, coad_pkg::AM_REG_IND, 0, 0, 16'h0000);
		chk("bitreg", {res_o.illegal, res_o.bit_num_reg}, 2'b01);
		run(coad_pkg::OP_BIT_IMMNUM, coad_pkg::AM_REG, 0, 0, 16'h0000);
		chk("bitregno", {res_o.illegal, res_o.bit_num_reg}, 2'b10);
		bfr = 1'b0;
	endtask
	task automatic t_stack();
		// Stack modes always use word size
		reg_m_val_i = 16'h0000;
		run(coad_pkg::OP_PUSH, coad_pkg::AM_PRE_DEC, 1, 1, 16'h0000);
		chk("pushea", res_o.ea, 16'hFFFE);
		chk("pushsp", res_o.new_reg_val, 16'hFFFE);
		chk("pushupd", res_o.reg_update, 1'b1);
		reg_m_val_i = 16'hFFFE;
		run(coad_pkg::OP_POP, coad_pkg::AM_POST_INC, 1, 0, 16'h0000);
		chk("popea", res_o.ea, 16'hFFFE);
		chk("popsp", res_o.new_reg_val, 16'h0000);
		chk("popidx", res_o.reg_update_idx, 3'h7);
		chk("popw", res_o.word, 1'b1);
	endtask
	task automatic t_branch();
		run(coad_pkg::OP_BCC, coad_pkg::AM_PC_REL, 0, 0, 16'h0080);
		chk("bneg", res_o.target, 16'h0F80);
		chk("cond", res_o.cond, 4'hA);
		chk("bclass", res_o.iclass, coad_pkg::CL_BRANCH);
		run(coad_pkg::OP_BCC, coad_pkg::AM_PC_REL, 0, 0, 16'h007F);
		chk("bodd", res_o.target, 16'h107E);
		lat = 4'h3;
		run(coad_pkg::OP_JUMP, coad_pkg::AM_MEM_IND, 1, 0, 16'h0035);
		chk("jslow", res_o.target, 16'hC334);
		chk("jvalid", res_o.target_valid, 1'b1);
		lat = 4'h0;
		run(coad_pkg::OP_JUMP, coad_pkg::AM_MEM_IND, 1, 0, 16'h00F0);
		chk("jfast", res_o.target, 16'hC3F0);
		run(coad_pkg::OP_PERIPH_TO, coad_pkg::AM_ABS16, 0, 1, 16'h4000);
		chk("pto", res_o.illegal, 1'b1);
		run(coad_pkg::OP_PERIPH_FROM, coad_pkg::AM_ABS16, 0, 0, 16'h4000);
		chk("pfrom", {res_o.illegal, res_o.mem_access}, 2'b10);
	endtask
	task automatic t_reset();
		// Reset in mid-fetch drops the pointer read and clears the result
		lat = 4'h3;
		insn_i = '{op: coad_pkg::OP_JUMP, mode: coad_pkg::AM_MEM_IND, word: 1'b1, store: 1'b0, reg_n: 3'h1,
			reg_m: 3'h7, bit_imm: 3'h5, bit_from_reg: 1'b0, cond: 4'hA, ext: 16'h0035, pc: 16'h1000};
		req_valid_i = 1'b1;
		@(posedge sys_clk_i);
		#1 req_valid_i = 1'b0;
		chk("fetching", mem_rd_o, 1'b1);
		sys_rst_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		chk("rst_state", {req_ready_o, mem_rd_o, res_valid_o}, 3'b100);
		chk("rst_res", {res_o.target_valid, res_o.illegal, res_o.mem_access}, 3'b000);
		chk("rst_target", res_o.target, 16'h0000);
		lat = 4'h0;
		run(coad_pkg::OP_JUMP, coad_pkg::AM_MEM_IND, 1, 0, 16'h0022);
		chk("jafter", res_o.target, 16'hC322);
	endtask
	initial
	begin
		#20000;
		mismatches++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		t_move();
		t_alu();
		t_bit();
		t_stack();
		t_branch();
		t_reset();
		stop_test();
	end
endmodule
